// *** inc/tym_params.svh ***
// Register offsets, field positions, reset values and timing counts of the timer block
`ifndef TYM_PARAMS_SVH
`define TYM_PARAMS_SVH
// ==========================================================
// Register offsets (byte addresses)
`define TYM_OFS_CNT_LO 8'h22
`define TYM_OFS_CNT_HI 8'h23
`define TYM_OFS_CTRL 8'h24
`define TYM_OFS_FLAGS 8'h25
// ==========================================================
// Control register fields
`define TYM_CTRL_MODE_LSB 0
`define TYM_CTRL_SLOW_BIT 2
`define TYM_CTRL_UIE_BIT 3
`define TYM_CTRL_EIE_BIT 4
`define TYM_CTRL_STOP_BIT 5
`define TYM_CTRL_EDGE_BIT 6
`define TYM_CTRL_RST 8'h00
// ==========================================================
// Flag register fields
`define TYM_FLG_UNF_BIT 0
`define TYM_FLG_EDG_BIT 1
// ==========================================================
// Counter reset value and prescaler
`define TYM_CNT_RST 16'hFFFF
`define TYM_PRESCALE 16
`endif

// *** inc/tym_pkg.sv ***
// Types shared by the timer block
package tym_pkg;
  typedef enum logic [1:0] {
    TYM_INTERVAL,
    TYM_PERIOD,
    TYM_EVENT,
    TYM_PULSE_HL
  } tym_mode_e;
endpackage

// *** verilog/tym_timer.sv ***
// 16-bit down counter with reload latch, measurement and event modes
`include "tym_params.svh"
module tym_timer
  import tym_pkg::*;
#(
  parameter int PRESCALE = `TYM_PRESCALE
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic main_oscillator,
  input wire logic sub_oscillator,
  input wire logic timer_input_pin,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic underflow_irq,
  output logic edge_irq
);
  // ==========================================================
  // Input synchronisers
  logic [2:0] pin_s_q;
  logic [2:0] main_s_q;
  logic [2:0] sub_s_q;
  logic pin_lvl_q;
  logic main_lvl_q;
  logic sub_lvl_q;

  // Three-stage synchronisers; level changes when stages two and three agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_s_q <= 3'h0;
      main_s_q <= 3'h0;
      sub_s_q <= 3'h0;
      pin_lvl_q <= 1'b0;
      main_lvl_q <= 1'b0;
      sub_lvl_q <= 1'b0;
    end else begin
      pin_s_q <= {pin_s_q[1:0], timer_input_pin};
      main_s_q <= {main_s_q[1:0], main_oscillator};
      sub_s_q <= {sub_s_q[1:0], sub_oscillator};
      if (pin_s_q[1] == pin_s_q[2]) pin_lvl_q <= pin_s_q[2];
      if (main_s_q[1] == main_s_q[2]) main_lvl_q <= main_s_q[2];
      if (sub_s_q[1] == sub_s_q[2]) sub_lvl_q <= sub_s_q[2];
    end
  end

  // ==========================================================
  // Control state
  logic [7:0] ctrl_q;
  logic unf_flag_q;
  logic edg_flag_q;
  logic [15:0] latch_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] hold_q;
  logic hold_q_valid;
  logic [7:0] wlo_q;
  logic [3:0] pre_q;
  logic pin_prev_q;
  logic osc_prev_q;

  // Field decode
  wire tym_mode_e mode = tym_mode_e'(ctrl_q[`TYM_CTRL_MODE_LSB +: 2]);
  wire slow = ctrl_q[`TYM_CTRL_SLOW_BIT];
  wire stop = ctrl_q[`TYM_CTRL_STOP_BIT];
  wire edge_sel = ctrl_q[`TYM_CTRL_EDGE_BIT];
  wire measure = (mode == TYM_PERIOD) || (mode == TYM_PULSE_HL);

  // Edge detection on filtered pin; bit 6 = 1 picks rising
  wire pin_rise = pin_lvl_q && !pin_prev_q;
  wire pin_fall = !pin_lvl_q && pin_prev_q;
  wire pin_sel_edge = edge_sel ? pin_rise : pin_fall;
  wire pin_any_edge = pin_rise || pin_fall;

  // Active input edge per mode
  wire in_edge = (mode == TYM_PULSE_HL) ? pin_any_edge :
                 (mode == TYM_INTERVAL) ? 1'b0 : pin_sel_edge;

  // Prescaler source: rising edges of the chosen oscillator
  wire osc_lvl = slow ? sub_lvl_q : main_lvl_q;
  wire osc_rise = osc_lvl && !osc_prev_q;
  wire pre_tick = osc_rise && (pre_q == 4'(PRESCALE - 1));

  // Count pulse selection
  wire count_pulse = !stop && ((mode == TYM_EVENT) ? pin_sel_edge : pre_tick);
  wire underflow = count_pulse && (cnt_q == 16'h0000);
  wire edge_reload = measure && in_edge;

  // Register access decode
  wire wr_lo = wr && (addr == `TYM_OFS_CNT_LO);
  wire wr_hi = wr && (addr == `TYM_OFS_CNT_HI);
  wire wr_ctrl = wr && (addr == `TYM_OFS_CTRL);
  wire wr_flags = wr && (addr == `TYM_OFS_FLAGS);
  wire rd_lo = rd && (addr == `TYM_OFS_CNT_LO);
  wire [15:0] wr_word = {wdata, wlo_q};
  wire [15:0] cnt_view = hold_q_valid ? hold_q : cnt_q;

  // Next counter value
  always_comb begin
    cnt_d = cnt_q;
    if (wr_hi) cnt_d = wr_word;
    else if (edge_reload) cnt_d = latch_q;
    else if (underflow) cnt_d = latch_q;
    else if (count_pulse) cnt_d = cnt_q - 16'h0001;
  end

  // Prescaler and edge history
  always_ff @(posedge mclk) begin
    if (rst) begin
      pre_q <= 4'h0;
      pin_prev_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_lvl_q;
      osc_prev_q <= osc_lvl;
      if (osc_rise) pre_q <= (pre_q == 4'(PRESCALE - 1)) ? 4'h0 : pre_q + 4'h1;
    end
  end

  // Counter, latch and low-byte staging
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= `TYM_CNT_RST;
      latch_q <= `TYM_CNT_RST;
      wlo_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
      if (wr_lo) wlo_q <= wdata;
      if (wr_hi) latch_q <= wr_word;
    end
  end

  // Hold of the pre-reload count until read out once
  always_ff @(posedge mclk) begin
    if (rst) begin
      hold_q <= 16'h0000;
      hold_q_valid <= 1'b0;
    end else if (edge_reload && !wr_hi) begin
      hold_q <= cnt_q;
      hold_q_valid <= 1'b1;
    end else if (rd_lo || wr_hi) begin
      hold_q_valid <= 1'b0;
    end
  end

  // Control register; stop bit clear after reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= `TYM_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata & 8'h7F;
    end
  end

  // Request flags; set beats write-one-to-clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      unf_flag_q <= 1'b0;
      edg_flag_q <= 1'b0;
    end else begin
      if (underflow) unf_flag_q <= 1'b1;
      else if (wr_flags && wdata[`TYM_FLG_UNF_BIT]) unf_flag_q <= 1'b0;
      if (in_edge) edg_flag_q <= 1'b1;
      else if (wr_flags && wdata[`TYM_FLG_EDG_BIT]) edg_flag_q <= 1'b0;
    end
  end

  // Read data mux
  wire [7:0] rd_mux = (addr == `TYM_OFS_CNT_HI) ? cnt_view[15:8] :
                      (addr == `TYM_OFS_CNT_LO) ? cnt_view[7:0] :
                      (addr == `TYM_OFS_CTRL) ? ctrl_q :
                      (addr == `TYM_OFS_FLAGS) ? {6'h00, edg_flag_q, unf_flag_q} : 8'h00;

  // Registered outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= 8'h00;
      underflow_irq <= 1'b0;
      edge_irq <= 1'b0;
    end else begin
      rdata <= rd ? rd_mux : 8'h00;
      underflow_irq <= unf_flag_q && ctrl_q[`TYM_CTRL_UIE_BIT];
      edge_irq <= edg_flag_q && ctrl_q[`TYM_CTRL_EIE_BIT];
    end
  end

  // ==========================================================
  // Assertions
  a_count_step: assert property (@(posedge mclk) disable iff (rst)
    (count_pulse && !underflow && !wr_hi && !edge_reload) |=> (cnt_q == $past(cnt_q) - 16'h0001))
    else $error("counter did not step by one");
  a_unf_reload: assert property (@(posedge mclk) disable iff (rst)
    (underflow && !wr_hi && !edge_reload) |=> (cnt_q == $past(latch_q)))
    else $error("underflow did not reload");
  a_unf_flag: assert property (@(posedge mclk) disable iff (rst)
    underflow |=> unf_flag_q)
    else $error("underflow flag not set");
  a_unf_irq: assert property (@(posedge mclk) disable iff (rst)
    (unf_flag_q && ctrl_q[`TYM_CTRL_UIE_BIT]) |=> underflow_irq)
    else $error("underflow irq not forwarded");
  a_stop_halt: assert property (@(posedge mclk) disable iff (rst)
    (stop && !wr_hi && !edge_reload) |=> $stable(cnt_q))
    else $error("counter moved while stopped");
  a_edge_reload: assert property (@(posedge mclk) disable iff (rst)
    (edge_reload && !wr_hi) |=> (cnt_q == $past(latch_q)))
    else $error("edge did not reload");
  sequence s_held;
    hold_q_valid && !rd_lo && !edge_reload;
  endsequence
  a_hold_keep: assert property (@(posedge mclk) disable iff (rst)
    (s_held and ##0 !wr_hi) |=> (hold_q_valid && $stable(hold_q)))
    else $error("held count lost before read");
  a_edge_flag: assert property (@(posedge mclk) disable iff (rst)
    in_edge |=> edg_flag_q)
    else $error("edge flag not set");
  a_write_load: assert property (@(posedge mclk) disable iff (rst)
    wr_hi |=> (cnt_q == $past(wr_word) && latch_q == $past(wr_word)))
    else $error("write did not load both");
  a_reset_run: assert property (@(posedge mclk) $fell(rst) |-> !stop)
    else $error("stop set after reset");
  // Request chains: flag one edge after the event, output one edge later
  sequence s_unf_armed;
    underflow && ctrl_q[`TYM_CTRL_UIE_BIT] && !wr_ctrl;
  endsequence
  sequence s_unf_chain;
    unf_flag_q ##1 underflow_irq;
  endsequence
  a_unf_chain: assert property (@(posedge mclk) disable iff (rst)
    s_unf_armed |=> s_unf_chain)
    else $error("underflow request chain broken");
  sequence s_edge_armed;
    in_edge && ctrl_q[`TYM_CTRL_EIE_BIT] && !wr_ctrl;
  endsequence
  sequence s_edge_chain;
    edg_flag_q ##1 edge_irq;
  endsequence
  a_edge_chain: assert property (@(posedge mclk) disable iff (rst)
    s_edge_armed |=> s_edge_chain)
    else $error("edge request chain broken");
  a_unf_irq_off: assert property (@(posedge mclk) disable iff (rst)
    !(unf_flag_q && ctrl_q[`TYM_CTRL_UIE_BIT]) |=> !underflow_irq)
    else $error("underflow irq without enabled flag");
  a_edge_irq_off: assert property (@(posedge mclk) disable iff (rst)
    !(edg_flag_q && ctrl_q[`TYM_CTRL_EIE_BIT]) |=> !edge_irq)
    else $error("edge irq without enabled flag");
  // Reload and hold paths of the measurement modes
  sequence s_capture;
    edge_reload && !wr_hi;
  endsequence
  sequence s_held_value;
    hold_q_valid && (hold_q == $past(cnt_q));
  endsequence
  a_hold_capture: assert property (@(posedge mclk) disable iff (rst)
    s_capture |=> s_held_value)
    else $error("pre-reload count not captured");
  a_hold_release: assert property (@(posedge mclk) disable iff (rst)
    (hold_q_valid && rd_lo && !edge_reload) |=> !hold_q_valid)
    else $error("held count kept after low read");
  a_meas_unf: assert property (@(posedge mclk) disable iff (rst)
    (measure && underflow && !edge_reload && !wr_hi) |=> (cnt_q == $past(latch_q)))
    else $error("measurement underflow did not reload");
  a_pulse_both: assert property (@(posedge mclk) disable iff (rst)
    ((mode == TYM_PULSE_HL) && pin_any_edge && !wr_hi) |=> (cnt_q == $past(latch_q)))
    else $error("pulse mode edge did not reload");
  a_fall_only: assert property (@(posedge mclk) disable iff (rst)
    ((mode == TYM_PERIOD) && !edge_sel && pin_rise) |-> !edge_reload)
    else $error("unselected edge reloaded");
  // Count source, pin filter and read path
  a_event_src: assert property (@(posedge mclk) disable iff (rst)
    ((mode == TYM_EVENT) && !pin_sel_edge) |-> !count_pulse)
    else $error("event mode counted without pin edge");
  a_stop_quiet: assert property (@(posedge mclk) disable iff (rst)
    stop |-> !underflow)
    else $error("underflow while stopped");
  a_pin_filter: assert property (@(posedge mclk) disable iff (rst)
    (pin_s_q[1] == pin_s_q[2]) |=> (pin_lvl_q == $past(pin_s_q[2])))
    else $error("filtered pin level did not follow");
  a_rd_idle: assert property (@(posedge mclk) disable iff (rst)
    !rd |=> (rdata == 8'h00))
    else $error("read data outside read cycle");
  a_rd_count: assert property (@(posedge mclk) disable iff (rst)
    (rd && (addr == `TYM_OFS_CNT_LO)) |=> (rdata == $past(cnt_view[7:0])))
    else $error("low count byte read wrong");
endmodule

// *** verif/tym_pin_src.sv ***
// External pulse source that drives the timer input pin
module tym_pin_src (
  input wire logic mclk,
  input wire logic lvl_req,
  input wire logic [1:0] lag,
  output logic timer_input_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] lag_q;
  logic pin_q = 1'b0;
  assign timer_input_pin = pin_q;
  // Pin follows the requested level after a random lag
  always @(posedge mclk) begin
    if (pin_q === lvl_req) begin
      lag_q <= {1'b0, lag};
    end else if (lag_q == 3'h0) begin
      pin_q <= lvl_req;
    end else begin
      lag_q <= lag_q - 3'h1;
    end
  end
endmodule

// *** verif/tym_timer_tb.sv ***
// Self-checking testbench of the timer block
module tym_timer_tb
  import tym_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, main_oscillator, sub_oscillator, lvl_req, wr, rd, pin;
  logic rd_p = 1'b0;
  logic [1:0] lag;
  logic [7:0] addr, wdata, rdata;
  logic underflow_irq, edge_irq;
  logic [7:0] exp_q[$];
  logic [31:0] rnd;
  int error_cnt, comparisons;
  integer seed;
  tym_timer #(.PRESCALE(2)) uut (.mclk(mclk), .rst(rst), .main_oscillator(main_oscillator),
    .sub_oscillator(sub_oscillator), .timer_input_pin(pin), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .underflow_irq(underflow_irq), .edge_irq(edge_irq));
  tym_pin_src src (.mclk(mclk), .lvl_req(lvl_req), .lag(lag), .timer_input_pin(pin));
  // ==========================================
  // Clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ==========================================
  // Tasks
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr16(input logic [15:0] v);
    wr_reg(8'h22, v[7:0]);
    wr_reg(8'h23, v[15:8]);
  endtask
  task automatic rd16(input logic [15:0] e);
    rd_reg(8'h23, e[15:8]);
    rd_reg(8'h22, e[7:0]);
    idle(1);
  endtask
  task automatic osc(input logic sel, input int n);
    repeat (n) begin
      if (sel) begin
        sub_oscillator <= 1'b1;
      end else begin
        main_oscillator <= 1'b1;
      end
      repeat (3) @(posedge mclk);
      sub_oscillator <= 1'b0;
      main_oscillator <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    repeat (10) @(posedge mclk);
  endtask
  task automatic pin_to(input logic l);
    rnd = $random(seed);
    lvl_req <= l;
    lag <= rnd[1:0];
    repeat (16) @(posedge mclk);
  endtask
  task automatic wait_irq(input logic sel);
    int n;
    n = 0;
    while (((sel ? edge_irq : underflow_irq) !== 1'b1) && n < 40) begin
      @(posedge mclk);
      n++;
    end
    chk("irq", 16'h0001, {15'h0000, sel ? edge_irq : underflow_irq});
    if (n >= 40) begin
      finish_test();
    end
  endtask
  // ==========================================
  // Read checker: oldest note against rdata
  always @(posedge mclk) begin
    rd_p <= rd;
    if (rd_p === 1'b1) begin
      chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata});
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    {rst, main_oscillator, sub_oscillator, lvl_req, wr, rd} = 6'h20;
    {lag, addr, wdata, error_cnt, comparisons, seed} = '0;
    seed = 32'h2ffe;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(8'h24, 8'h00);
    rd16(16'hFFFF);
    rnd = $random(seed);
    wr_reg(8'h30, rnd[7:0]);
    rd_reg(8'h30, 8'h00);
    idle(1);
    $display("test reset done");
    wr16(16'h0003);
    wr_reg(8'h24, 8'h08);
    idle(1);
    osc(1'b0, 6);
    rd16(16'h0000);
    chk("underflow_irq", 16'h0000, {15'h0000, underflow_irq});
    osc(1'b0, 2);
    rd16(16'h0003);
    wait_irq(1'b0);
    wr_reg(8'h25, 8'h01);
    idle(4);
    chk("underflow_irq", 16'h0000, {15'h0000, underflow_irq});
    wr_reg(8'h24, 8'h04);
    idle(1);
    osc(1'b0, 4);
    osc(1'b1, 4);
    rd16(16'h0001);
    rnd = $random(seed);
    wr16(rnd[15:0]);
    wr_reg(8'h24, 8'h20);
    idle(1);
    osc(1'b0, 4);
    rd16(rnd[15:0]);
    $display("test interval done");
    wr16(16'h0005);
    wr_reg(8'h24, 8'h42);
    idle(1);
    repeat (3) begin
      pin_to(1'b1);
      pin_to(1'b0);
    end
    rd16(16'h0002);
    rd_reg(8'h25, 8'h02);
    idle(1);
    chk("edge_irq", 16'h0000, {15'h0000, edge_irq});
    wr_reg(8'h24, 8'h52);
    idle(1);
    wait_irq(1'b1);
    repeat (3) begin
      pin_to(1'b1);
      pin_to(1'b0);
    end
    rd16(16'h0005);
    rd_reg(8'h25, 8'h03);
    wr_reg(8'h25, 8'h03);
    $display("test event done");
    wr16(16'h0100);
    wr_reg(8'h24, 8'h01);
    idle(1);
    osc(1'b0, 20);
    pin_to(1'b1);
    pin_to(1'b0);
    osc(1'b0, 4);
    rd16(16'h0100 - 16'h000A);
    rd16(16'h00FE);
    wr16(16'h0100);
    wr_reg(8'h24, 8'h03);
    idle(1);
    osc(1'b0, 20);
    pin_to(1'b1);
    rd16(16'h00F6);
    osc(1'b0, 6);
    pin_to(1'b0);
    rd16(16'h00FD);
    rd16(16'h0100);
    rd_reg(8'h25, 8'h02);
    idle(2);
    $display("test measure done");
    finish_test();
  end
endmodule
